/* design/qwb_wiper_bank.sv */
// four-channel wiper register bank behind a two-wire serial target
module qwb_wiper_bank import qwb_pkg::*; #(
  parameter logic [2:0] DEV_ID = 3'h2 // fixed address bits, value arbitrary
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // serial bus pins
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // straps and guard
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic addr_select_bit3,
  input wire logic wr_guard_n,
  // wiper state towards the resistor arrays
  output logic [NUM_CH-1:0][DATA_W-1:0] wiper_position_reg,
  output logic [NUM_CH-1:0][NUM_TAPS-1:0] tap_sel
);
  qwb_pins_t pins;
  qwb_bank_t q;
  qwb_bank_t d;

  qwb_pin_front u_front (
    .mclk(mclk),
    .rstn(rstn),
    .scl(scl),
    .sda(sda_i),
    .wr_guard_n(wr_guard_n),
    .addr_pins({addr_select_bit3, addr_select_bit2, addr_select_bit1, addr_select_bit0}),
    .pins(pins)
  );

  // four stored slots per channel
  // register addressed by the read pointer
  function automatic logic [DATA_W-1:0] rd_sel(input qwb_bank_t s);
    return s.rd_nv ? s.stored[s.ch][s.idx] : s.wiper[s.ch];
  endfunction

  // saturating single step, so the wiper never wraps end to end
  function automatic logic [DATA_W-1:0] step(input logic [DATA_W-1:0] w, input logic up);
    if (up) begin
      return (w == WIPER_MAX) ? w : w + 8'h01;
    end
    return (w == WIPER_MIN) ? w : w - 8'h01;
  endfunction

  // protocol engine and register updates
  always_comb begin
    d = q;
    if (q.st == ST_RECALL) begin
      for (int c = 0; c < NUM_CH; c++) begin
        d.wiper[c] = q.stored[c][0];
      end
      d.st = ST_IDLE;
    end else if (pins.start) begin
      // a start always resynchronises the engine
      d.st = ST_ADDR;
      d.cnt = 3'h0;
      d.done = 1'b0;
      d.sda_oe_n = 1'b1;
    end else if (pins.stop) begin
      d.st = ST_IDLE;
      d.sda_oe_n = 1'b1;
    end else begin
      case (q.st)
        ST_ADDR, ST_INSTR, ST_WDATA: begin
          if (pins.scl_rise && !q.done) begin
            d.sh = {q.sh[DATA_W-2:0], pins.sda};
            d.cnt = q.cnt + 3'h1;
            d.done = (q.cnt == LAST_BIT);
          end else if (pins.scl_fall && q.done) begin
            d.done = 1'b0;
            d.cnt = 3'h0;
            d.sda_oe_n = 1'b0;
            if (q.st == ST_ADDR) begin
              if (q.sh[7:1] == {DEV_ID, pins.addr}) begin
                d.rw = q.sh[0];
                d.st = ST_ADDR_ACK;
              end else begin
                d.sda_oe_n = 1'b1;
                d.st = ST_IGNORE;
              end
            end else if (q.st == ST_INSTR) begin
              d.op = q.sh[OP_HI:OP_LO];
              d.ch = q.sh[CH_HI:CH_LO];
              d.idx = q.sh[IDX_HI:IDX_LO];
              d.rd_nv = (q.sh[OP_HI:OP_LO] == OP_RD_STORED);
              d.st = ST_INSTR_ACK;
              case (q.sh[OP_HI:OP_LO])
                OP_RD_WIPER, OP_RD_STORED, OP_WR_WIPER, OP_WR_STORED, OP_STEP: begin
                end
                OP_LOAD_WIPER: begin
                  d.wiper[q.sh[CH_HI:CH_LO]] = q.stored[q.sh[CH_HI:CH_LO]][q.sh[IDX_HI:IDX_LO]];
                end
                OP_SAVE_WIPER: begin
                  if (pins.wp_ok) begin
                    d.stored[q.sh[CH_HI:CH_LO]][q.sh[IDX_HI:IDX_LO]] = q.wiper[q.sh[CH_HI:CH_LO]];
                  end
                end
                default: begin
                  d.sda_oe_n = 1'b1;
                  d.st = ST_IGNORE;
                end
              endcase
            end else begin
              // data byte writes only from the bus
              d.st = ST_WDATA_ACK;
              case (q.op)
                OP_WR_WIPER: d.wiper[q.ch] = q.sh;
                OP_WR_STORED: begin
                  if (pins.wp_ok) begin
                    d.stored[q.ch][q.idx] = q.sh;
                  end
                end
                // step mode, bit 0 picks direction
                OP_STEP: d.wiper[q.ch] = step(q.wiper[q.ch], q.sh[0]);
                default: begin
                end
              endcase
            end
          end
        end
        ST_ADDR_ACK: begin
          if (pins.scl_fall) begin
            d.cnt = 3'h0;
            if (q.rw) begin
              d.tx = rd_sel(q);
              d.sda_oe_n = d.tx[DATA_W-1];
              d.st = ST_RDATA;
            end else begin
              d.sda_oe_n = 1'b1;
              d.st = ST_INSTR;
            end
          end
        end
        ST_INSTR_ACK, ST_WDATA_ACK: begin
          if (pins.scl_fall) begin
            d.sda_oe_n = 1'b1;
            d.st = ST_WDATA;
          end
        end
        // a one bit releases the line
        ST_RDATA: begin
          if (pins.scl_fall) begin
            if (q.cnt == LAST_BIT) begin
              d.sda_oe_n = 1'b1;
              d.st = ST_RACK;
            end else begin
              d.tx = {q.tx[DATA_W-2:0], 1'b0};
              d.cnt = q.cnt + 3'h1;
              d.sda_oe_n = d.tx[DATA_W-1];
            end
          end
        end
        ST_RACK: begin
          if (pins.scl_rise) begin
            d.ack_ok = !pins.sda;
          end else if (pins.scl_fall) begin
            if (q.ack_ok) begin
              d.tx = rd_sel(q);
              d.cnt = 3'h0;
              d.sda_oe_n = d.tx[DATA_W-1];
              d.st = ST_RDATA;
            end else begin
              d.st = ST_IGNORE;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // one-hot tap decode of each wiper
    for (int c = 0; c < NUM_CH; c++) begin
      d.tap[c] = {{(NUM_TAPS-1){1'b0}}, 1'b1} << d.wiper[c];
    end
    d.sda_o = 1'b0;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= BANK_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs are plain flop copies
  assign sda_o = q.sda_o;
  assign sda_oe_n = q.sda_oe_n;
  assign wiper_position_reg = q.wiper;
  assign tap_sel = q.tap;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_tap_chk
    tap_match_a: assert property ($onehot(q.tap[g]) && q.tap[g][q.wiper[g]])
      else $error("tap select does not match wiper");
  end
  wiper_cause_a: assert property (!$stable(q.wiper) |-> $past(q.st == ST_RECALL || pins.scl_fall))
    else $error("wiper changed without a cause");
  recall_load_a: assert property (q.st == ST_RECALL |=> q.wiper[3] == $past(q.stored[3][0]))
    else $error("power-up recall missing");
  stored_cause_a: assert property (!$stable(q.stored) |-> $past(pins.scl_fall && q.st inside {ST_INSTR, ST_WDATA}))
    else $error("stored setting changed off the bus");
  addr_match_a: assert property (q.st == ST_ADDR_ACK |-> q.sh[7:1] == {DEV_ID, pins.addr})
    else $error("ack given for wrong address");
  drive_low_a: assert property (!q.sda_oe_n |-> q.st inside {ST_ADDR_ACK, ST_INSTR_ACK, ST_WDATA_ACK, ST_RDATA})
    else $error("data line driven outside ack or read");
  guard_hold_a: assert property ($past(!pins.wp_ok) |-> $stable(q.stored))
    else $error("stored write while guarded");
  load_xfer_a: assert property (q.st == ST_INSTR && q.done && pins.scl_fall && !pins.start && !pins.stop
      && q.sh[OP_HI:OP_LO] == OP_LOAD_WIPER
      |=> q.wiper[$past(q.sh[CH_HI:CH_LO])] == $past(q.stored[q.sh[CH_HI:CH_LO]][q.sh[IDX_HI:IDX_LO]]))
    else $error("load transfer failed");
  ignore_quiet_a: assert property (q.st == ST_IGNORE && $past(q.st == ST_IGNORE)
      |-> q.sda_oe_n && $stable(q.wiper) && $stable(q.stored))
    else $error("activity while ignoring");

  read_done_c: cover property (q.st == ST_RACK ##1 q.st == ST_IGNORE);
  nv_write_c: cover property (q.st == ST_WDATA && q.op == OP_WR_STORED ##1 q.st == ST_WDATA_ACK);
  step_c: cover property (q.st == ST_WDATA && q.op == OP_STEP ##1 q.st == ST_WDATA_ACK);
  mismatch_c: cover property (q.st == ST_ADDR ##1 q.st == ST_IGNORE);
endmodule

/* inc/qwb_pkg.sv */
// shared constants and types for the quad wiper register bank
package qwb_pkg;
  // channel and storage geometry
  localparam int NUM_CH = 4;
  localparam int NUM_SLOT = 4;
  localparam int DATA_W = 8;
  localparam int NUM_TAPS = 256;
  localparam int ADDR_PINS = 4;
  // instruction byte fields
  localparam int OP_HI = 7;
  localparam int OP_LO = 4;
  localparam int CH_HI = 3;
  localparam int CH_LO = 2;
  localparam int IDX_HI = 1;
  localparam int IDX_LO = 0;
  // instruction codes
  localparam logic [3:0] OP_STEP = 4'h2;
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'ha;
  localparam logic [3:0] OP_RD_STORED = 4'hb;
  localparam logic [3:0] OP_WR_STORED = 4'hc;
  localparam logic [3:0] OP_LOAD_WIPER = 4'hd;
  localparam logic [3:0] OP_SAVE_WIPER = 4'he;
  // bit counting and reset values
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] STORED_RESET = 8'h80;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [7:0] WIPER_MAX = 8'hff;
  localparam logic [7:0] WIPER_MIN = 8'h00;
  localparam logic [NUM_TAPS-1:0] TAP_RESET = {{(NUM_TAPS-1){1'b0}}, 1'b1} << WIPER_RESET;

  typedef enum logic [3:0] {
    ST_RECALL, ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } qwb_state_t;

  // one sample of the external pins
  typedef struct packed {
    logic scl;
    logic sda;
    logic guard_n;
    logic [ADDR_PINS-1:0] addr;
  } qwb_sync_t;

  // decoded bus events towards the bank
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic wp_ok;
    logic [ADDR_PINS-1:0] addr;
  } qwb_pins_t;

  typedef struct packed {
    qwb_sync_t s1;
    qwb_sync_t s2;
    qwb_sync_t last;
  } qwb_front_t;

  typedef struct packed {
    qwb_state_t st;
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] tx;
    logic [2:0] cnt;
    logic done;
    logic rw;
    logic ack_ok;
    logic rd_nv;
    logic [1:0] ch;
    logic [1:0] idx;
    logic [3:0] op;
    logic sda_oe_n;
    logic sda_o;
    logic [NUM_CH-1:0][DATA_W-1:0] wiper;
    logic [NUM_CH-1:0][NUM_SLOT-1:0][DATA_W-1:0] stored;
    logic [NUM_CH-1:0][NUM_TAPS-1:0] tap;
  } qwb_bank_t;

  localparam qwb_bank_t BANK_RESET = '{
    st: ST_RECALL, sda_oe_n: 1'b1,
    wiper: {NUM_CH{WIPER_RESET}},
    stored: {(NUM_CH*NUM_SLOT){STORED_RESET}},
    tap: {NUM_CH{TAP_RESET}},
    default: '0
  };
endpackage

/* design/qwb_pin_front.sv */
// pin synchronisers and start, stop and clock edge detection
module qwb_pin_front import qwb_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // raw pins
  input wire logic scl,
  input wire logic sda,
  input wire logic wr_guard_n,
  input wire logic [ADDR_PINS-1:0] addr_pins,
  // decoded events
  output qwb_pins_t pins
);
  qwb_front_t q;
  qwb_front_t d;

  // two flops per pin, then one history stage for edges
  always_comb begin
    d = q;
    d.s1 = '{scl: scl, sda: sda, guard_n: wr_guard_n, addr: addr_pins};
    d.s2 = q.s1;
    d.last = q.s2;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= '{s1: '1, s2: '1, last: '1};
    end else begin
      q <= d;
    end
  end

  // events are combinational to save a cycle of the short ack window
  assign pins.scl_rise = q.s2.scl && !q.last.scl;
  assign pins.scl_fall = !q.s2.scl && q.last.scl;
  assign pins.start = q.s2.scl && q.last.scl && !q.s2.sda && q.last.sda;
  assign pins.stop = q.s2.scl && q.last.scl && q.s2.sda && !q.last.sda;
  assign pins.sda = q.s2.sda;
  assign pins.wp_ok = q.s2.guard_n;
  assign pins.addr = q.s2.addr;
endmodule

/* verif/qwb_ctrl_model.sv */
// serial bus controller model that times every transfer with its own clock
module qwb_ctrl_model (
  // serial bus towards the target
  output logic scl,
  output logic sda_drv,
  input wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // both lines idle high; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // controller owns clock
  // one bit slot: 100 ns low then 60 ns high, a 160 ns period; low phase covers the answer delay
  task automatic bit_slot(input logic b, output logic r);
    #40 sda_drv = b;
    #60 scl = 1'b1;
    r = sda_wire;
    #60 scl = 1'b0;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    #40 sda_drv = 1'b1;
    #60 scl = 1'b1;
    #60 sda_drv = 1'b0;
    #60 scl = 1'b0;
  endtask

  // stop: data rises while the clock is high, then lines stay released
  task automatic stop_cond();
    #40 sda_drv = 1'b0;
    #60 scl = 1'b1;
    #60 sda_drv = 1'b1;
    #100;
  endtask

  // writes only by bus
  // byte out msb first; the ninth slot releases data so the target can acknowledge
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(v[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask

  // byte in msb first; nack high ends the read
  task automatic recv_byte(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      v[i] = r;
    end
    bit_slot(nack, r);
  endtask
endmodule

/* verif/qwb_wiper_bank_tb.sv */
// self-checking bench for the quad wiper register bank
module qwb_wiper_bank_tb import qwb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] ID = 3'h2; // fixed address bits, value arbitrary
  logic mclk, rstn, wr_guard_n, sda_o, sda_oe_n;
  logic [3:0] straps;
  wire scl, sda_drv, sda_wire;
  logic [NUM_CH-1:0][DATA_W-1:0] wiper;
  logic [NUM_CH-1:0][NUM_TAPS-1:0] taps;
  int mismatches, check_count;

  // pulled-up wire: low whenever either party pulls it
  assign sda_wire = (sda_oe_n ? 1'b1 : sda_o) & sda_drv;

  qwb_ctrl_model ctl (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));
  qwb_wiper_bank #(.DEV_ID(ID)) uut (
    .mclk(mclk), .rstn(rstn), .scl(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .addr_select_bit0(straps[0]), .addr_select_bit1(straps[1]), .addr_select_bit2(straps[2]),
    .addr_select_bit3(straps[3]), .wr_guard_n(wr_guard_n), .wiper_position_reg(wiper), .tap_sel(taps));

  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string name, input logic [255:0] seen, input logic [255:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // write frame: address, instruction, optional data byte; ok only if every byte was acknowledged
  task automatic wr(input logic [3:0] a, input logic [7:0] ins, input logic nd, input logic [7:0] d,
                    output logic ok);
    logic k0, k1, k2;
    k2 = 1'b1;
    ctl.start_cond();
    ctl.send_byte({ID, a, 1'b0}, k0);
    ctl.send_byte(ins, k1);
    if (nd) ctl.send_byte(d, k2);
    ctl.stop_cond();
    ok = k0 & k1 & k2;
  endtask

  // read frame through a repeated start, one byte then nack
  task automatic rd(input logic [7:0] ins, output logic [7:0] v);
    logic k;
    ctl.start_cond();
    ctl.send_byte({ID, straps, 1'b0}, k);
    ctl.send_byte(ins, k);
    ctl.start_cond();
    ctl.send_byte({ID, straps, 1'b1}, k);
    ctl.recv_byte(1'b1, v);
    ctl.stop_cond();
  endtask

  task automatic t_reset();
    for (int c = 0; c < NUM_CH; c++) begin
      chk("wiper after recall", wiper[c], 8'h80);
      chk("tap after recall", taps[c], 256'h1 << 128);
    end
    chk("data released", sda_oe_n, 1'b1);
  endtask

  task automatic t_write_wiper();
    logic ok;
    wr(straps, {OP_WR_WIPER, 2'h1, 2'h0}, 1'b1, 8'h40, ok);
    chk("frame acked", ok, 1'b1);
    chk("wiper1", wiper[1], 8'h40);
    chk("tap1 one-hot", taps[1], 256'h1 << 64);
    chk("wiper0 untouched", wiper[0], 8'h80);
  endtask

  task automatic t_stored_moves();
    logic ok;
    logic [7:0] v;
    wr(straps, {OP_WR_STORED, 2'h2, 2'h3}, 1'b1, 8'h5a, ok);
    rd({OP_RD_STORED, 2'h2, 2'h3}, v);
    chk("stored2.3", v, 8'h5a);
    chk("wiper2 before load", wiper[2], 8'h80);
    wr(straps, {OP_LOAD_WIPER, 2'h2, 2'h3}, 1'b0, 8'h00, ok);
    chk("wiper2 loaded", wiper[2], 8'h5a);
    wr(straps, {OP_SAVE_WIPER, 2'h1, 2'h0}, 1'b0, 8'h00, ok);
    rd({OP_RD_STORED, 2'h1, 2'h0}, v);
    chk("stored1.0 saved", v, 8'h40);
    rd({OP_RD_WIPER, 2'h2, 2'h0}, v);
    chk("wiper2 read", v, 8'h5a);
  endtask

  task automatic t_step();
    logic ok;
    wr(straps, {OP_WR_WIPER, 2'h3, 2'h0}, 1'b1, 8'hff, ok);
    wr(straps, {OP_STEP, 2'h3, 2'h0}, 1'b1, 8'h01, ok);
    chk("step up saturates", wiper[3], 8'hff);
    wr(straps, {OP_STEP, 2'h3, 2'h0}, 1'b1, 8'h00, ok);
    chk("step down", wiper[3], 8'hfe);
    chk("tap3 follows", taps[3], 256'h1 << 254);
  endtask

  task automatic t_guard();
    logic ok;
    logic [7:0] v;
    @(posedge mclk) wr_guard_n <= 1'b0;
    wr(straps, {OP_WR_STORED, 2'h0, 2'h1}, 1'b1, 8'h33, ok);
    rd({OP_RD_STORED, 2'h0, 2'h1}, v);
    chk("guarded stored", v, 8'h80);
    wr(straps, {OP_WR_WIPER, 2'h0, 2'h0}, 1'b1, 8'h33, ok);
    chk("wiper under guard", wiper[0], 8'h33);
    @(posedge mclk) wr_guard_n <= 1'b1;
  endtask

  // straps 0101: a mismatch and a bit-reversed address must both be ignored
  task automatic t_address();
    logic ok;
    @(posedge mclk) straps <= 4'h5;
    repeat (4) @(posedge mclk);
    wr(4'h0, {OP_WR_WIPER, 2'h0, 2'h0}, 1'b1, 8'h11, ok);
    chk("mismatch nack", ok, 1'b0);
    chk("mismatch no write", wiper[0], 8'h33);
    wr(4'ha, {OP_WR_WIPER, 2'h0, 2'h0}, 1'b1, 8'h11, ok);
    chk("reversed nack", ok, 1'b0);
    wr(4'h5, {OP_WR_WIPER, 2'h0, 2'h0}, 1'b1, 8'h11, ok);
    chk("match ack", ok, 1'b1);
    chk("match write", wiper[0], 8'h11);
    // an undefined opcode is refused at its instruction ack, so the data byte is dropped
    wr(4'h5, 8'h00, 1'b1, 8'h22, ok);
    chk("bad opcode nack", ok, 1'b0);
    chk("bad opcode no write", wiper[0], 8'h11);
  endtask

  // main sequence: 8-cycle reset, settle, then scenarios
  initial begin
    rstn = 1'b0;
    wr_guard_n = 1'b1;
    straps = 4'h0;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    t_reset();
    t_write_wiper();
    t_stored_moves();
    t_step();
    t_guard();
    t_address();
    tally_and_finish();
  end

  // watchdog: scenarios need roughly 85 us of bus time
  initial begin
    #500000;
    mismatches++;
    tally_and_finish();
  end
endmodule
